/* guest_irq_pkg.sv */
// Purpose: constants for the guest interrupt virtualization block
// Assumes: six shared external lines, 32-bit APB register access
// Notes:   offsets are byte addresses of aligned words
package guest_irq_pkg;
  localparam int unsigned LINES = 6;
  localparam int unsigned PEND_W = 8;
  localparam int unsigned LINE_LSB = 2;
  localparam logic [7:0] OFF_PASSTHRU = 8'h00;
  localparam logic [7:0] OFF_VPEND = 8'h04;
  localparam logic [7:0] OFF_HWCLR = 8'h08;
  localparam logic [7:0] OFF_GCTRL = 8'h0C;
  localparam logic [7:0] OFF_GPEND = 8'h10;
  localparam logic [7:0] OFF_RPEND = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h20;
  localparam logic [7:0] OFF_PRIO = 8'h24;
  localparam logic [5:0] LINE_RST = 6'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [2:0] SEL_RST = 3'h7;
  localparam logic [5:0] PRIO_RST = 6'h00;
  localparam int unsigned SEL_TIMER_LSB = 0;
  localparam int unsigned SEL_SOFT_LSB = 3;
  localparam int unsigned GC_BEV = 6;
  localparam int unsigned GC_IV = 7;
  localparam int unsigned GC_VS_LSB = 8;
  localparam int unsigned GC_EXTMODE = 13;
  localparam int unsigned EV_FIELD = 0;
  localparam int unsigned EV_HANDOFF = 1;
  localparam int unsigned EV_W = 2;
endpackage

/* guest_irq_virt.sv */
// Purpose: root/guest cause pending generation for shared irq lines
// Assumes: software reaches all registers over APB, zero wait states; guest config and mode arrive on ports
// Notes:   external lines are synchronized before use
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - root detection stays active in guest mode
// - root pending outranks guest pending
// - guest pending ORs passthrough, internal, injected
// - guest timer drives selected pending bit
// - guest software irq drives selected bit
// - passthrough routes line n to bit n+2
// - virtual pending set/clear, set wins
// - without hardware clear, bit holds
// - guest bit = line&passthru | virtual
// - root bit masks passthru and cleared injection
// - virtual and hardware clear present, writable
// - shadow copy kept only without virtual field
// - shadow omitted since virtual pending exists
// - guest vector field change raises exception
// - six lines shared by both contexts
// - non-external mode injects via virtual pending
// - handed-over level fires on guest entry
module guest_irq_virt
  import guest_irq_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [LINES-1:0]    external_irq_lines,
  input  wire logic                guest_timer_irq,
  input  wire logic [1:0]          guest_soft_irq,
  input  wire logic                guest_mode,
  input  wire logic                guest_config_write,
  input  wire logic [31:0]         guest_config_wdata,
  output logic      [PEND_W-1:0]   root_pending,
  output logic      [PEND_W-1:0]   guest_pending,
  output logic                     root_take,
  output logic                     guest_take,
  output logic                     field_change_exc,
  output logic                     guest_prio_irq,
  output logic                     irq
);
  logic [LINES-1:0]  sync1_q, sync2_q, line_prev_q;
  logic [LINES-1:0]  pending_passthrough_mask_q;
  logic [LINES-1:0]  virtual_pending_q;
  logic [LINES-1:0]  hardware_clear_enable_q;
  logic [5:0]        sel_q;
  logic [13:0]       interrupt_config_q;
  logic [5:0]        captured_guest_priority_level_q;
  logic [EV_W-1:0]   stat_q, en_q, stat_d, en_d;
  logic              guest_mode_prev_q;
  logic [LINES-1:0]  deassert;
  logic [PEND_W-1:0] root_d, guest_d, internal_d;
  logic              wr, rd, field_chg, handoff;
  logic [31:0]       rdata_d;
  logic [EV_W-1:0]   ev;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= LINE_RST;
      sync2_q <= LINE_RST;
      line_prev_q <= LINE_RST;
    end else begin
      sync1_q <= external_irq_lines;
      sync2_q <= sync1_q;
      line_prev_q <= sync2_q;
    end
  end

  assign deassert = line_prev_q & ~sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_passthrough_mask_q <= LINE_RST;
      hardware_clear_enable_q <= LINE_RST;
      sel_q <= {SEL_RST, SEL_RST};
      captured_guest_priority_level_q <= PRIO_RST;
    end else if (wr) begin
      if (paddr == OFF_PASSTHRU) begin
        pending_passthrough_mask_q <= pwdata[LINES-1:0];
      end else if (paddr == OFF_HWCLR) begin
        // hardware clear field writable per bit
        hardware_clear_enable_q <= pwdata[LINES-1:0];
      end else if (paddr == OFF_GCTRL) begin
        sel_q <= pwdata[5:0];
      end else if (paddr == OFF_PRIO) begin
        captured_guest_priority_level_q <= pwdata[5:0];
      end
    end
  end

  // virtual pending per line, set write wins
  // no hardware clear leaves bit set
  // virtual field present so it is the pending copy
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_vp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          virtual_pending_q[g] <= 1'b0;
        end else if (wr && paddr == OFF_VPEND && pwdata[g]) begin
          virtual_pending_q[g] <= 1'b1;
        end else if (wr && paddr == OFF_VPEND) begin
          virtual_pending_q[g] <= 1'b0;
        end else if (deassert[g] && hardware_clear_enable_q[g]) begin
          virtual_pending_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    internal_d = PEND_RST;
    internal_d[sel_q[SEL_TIMER_LSB +: 3]] = guest_timer_irq;
    internal_d[sel_q[SEL_SOFT_LSB +: 3]] =
      internal_d[sel_q[SEL_SOFT_LSB +: 3]] | (|guest_soft_irq);
    internal_d[1:0] = internal_d[1:0] | guest_soft_irq;
  end

  always_comb begin
    root_d = PEND_RST;
    guest_d = internal_d;
    // line n to bit n+2 by passthrough
    // guest bit from line and virtual
    // root bit hides passthrough and cleared injection
    root_d[LINE_LSB +: LINES] = sync2_q & ~(pending_passthrough_mask_q
      | (virtual_pending_q & hardware_clear_enable_q));
    guest_d[LINE_LSB +: LINES] = internal_d[LINE_LSB +: LINES]
      | (sync2_q & pending_passthrough_mask_q) | virtual_pending_q;
  end

  // root side never gated by guest state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      root_pending <= PEND_RST;
      guest_pending <= PEND_RST;
      root_take <= 1'b0;
      guest_take <= 1'b0;
    end else begin
      root_pending <= root_d;
      guest_pending <= guest_d;
      root_take <= |root_d;
      guest_take <= (|guest_d) && !(|root_d);
    end
  end

  assign field_chg = guest_config_write &&
    ((guest_config_wdata[GC_BEV] != interrupt_config_q[GC_BEV]) ||
     (guest_config_wdata[GC_IV] != interrupt_config_q[GC_IV]) ||
     (guest_config_wdata[GC_VS_LSB +: 5] !=
      interrupt_config_q[GC_VS_LSB +: 5]));

  assign handoff = guest_mode && !guest_mode_prev_q &&
    (captured_guest_priority_level_q != PRIO_RST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_config_q <= 14'h0000;
      field_change_exc <= 1'b0;
      guest_prio_irq <= 1'b0;
      guest_mode_prev_q <= 1'b0;
    end else begin
      if (guest_config_write) begin
        interrupt_config_q <= guest_config_wdata[13:0];
      end
      field_change_exc <= field_chg;
      guest_prio_irq <= handoff;
      guest_mode_prev_q <= guest_mode;
    end
  end

  assign ev = {handoff, field_chg};

  // sticky status, set beats clear
  always_comb begin
    stat_d = stat_q | ev;
    en_d = en_q;
    if (wr && paddr == OFF_IRQ_CLR) begin
      stat_d = (stat_q & ~pwdata[EV_W-1:0]) | ev;
    end
    if (wr && paddr == OFF_IRQ_EN) begin
      en_d = pwdata[EV_W-1:0];
    end
  end

  // irq built from next status, no stale cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 2'h0;
      en_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      en_q <= en_d;
      irq <= |(stat_d & en_d);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == OFF_PASSTHRU) begin
      rdata_d[LINES-1:0] = pending_passthrough_mask_q;
    end else if (paddr == OFF_VPEND) begin
      rdata_d[LINES-1:0] = virtual_pending_q;
    end else if (paddr == OFF_HWCLR) begin
      rdata_d[LINES-1:0] = hardware_clear_enable_q;
    end else if (paddr == OFF_GCTRL) begin
      rdata_d[5:0] = sel_q;
    end else if (paddr == OFF_GPEND) begin
      rdata_d[PEND_W-1:0] = guest_d;
    end else if (paddr == OFF_RPEND) begin
      rdata_d[PEND_W-1:0] = root_d;
    end else if (paddr == OFF_IRQ_STAT) begin
      rdata_d[EV_W-1:0] = stat_q;
    end else if (paddr == OFF_IRQ_EN) begin
      rdata_d[EV_W-1:0] = en_q;
    end else if (paddr == OFF_PRIO) begin
      rdata_d[5:0] = captured_guest_priority_level_q;
    end
  end

  // zero-wait apb answer, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // guest bit follows line and virtual
  guest_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> guest_pending[LINE_LSB +: LINES] ==
      ($past(internal_d[LINE_LSB +: LINES]) | ($past(sync2_q)
      & $past(pending_passthrough_mask_q)) | $past(virtual_pending_q)))
    else $error("guest pending mismatch");
  root_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> root_pending[LINE_LSB +: LINES] == ($past(sync2_q)
      & ~($past(pending_passthrough_mask_q) | ($past(virtual_pending_q)
      & $past(hardware_clear_enable_q)))))
    else $error("root pending mismatch");
  vpend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_VPEND && pwdata[0]) |=> virtual_pending_q[0])
    else $error("virtual set lost");
  vpend_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (virtual_pending_q[0] && !hardware_clear_enable_q[0] && !wr)
      |=> virtual_pending_q[0])
    else $error("virtual bit dropped");
  root_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
    root_take |-> !guest_take)
    else $error("guest taken over root");
  field_chg_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_chg |=> field_change_exc)
    else $error("field change missed");
  handoff_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(guest_mode) && captured_guest_priority_level_q != 6'h00)
      |=> guest_prio_irq)
    else $error("handoff missed");
  timer_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    guest_timer_irq |=> guest_pending[$past(sel_q[2:0])])
    else $error("timer not pending");
  soft_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|guest_soft_irq) |=> guest_pending[$past(sel_q[5:3])])
    else $error("software irq not pending");
  // software bit also on low bits
  soft_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    guest_soft_irq[1] |=> guest_pending[1])
    else $error("software low bit missing");
  vpend_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_VPEND && !pwdata[0]) |=> !virtual_pending_q[0])
    else $error("virtual clear lost");
  hw_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (deassert[0] && hardware_clear_enable_q[0]
      && !(wr && paddr == OFF_VPEND && pwdata[0]))
      |=> !virtual_pending_q[0])
    else $error("hardware clear missed");
  hc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_HWCLR)
      |=> hardware_clear_enable_q == $past(pwdata[LINES-1:0]))
    else $error("hardware clear write lost");
  // root line seen in guest mode
  root_live_a: assert property (@(posedge pclk) disable iff (!presetn)
    (guest_mode && |(sync2_q & ~pending_passthrough_mask_q
      & ~hardware_clear_enable_q)) |=> root_take)
    else $error("root irq lost in guest mode");
  pass_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2_q[0] && pending_passthrough_mask_q[0])
      |=> (guest_pending[LINE_LSB] && !root_pending[LINE_LSB]))
    else $error("passthrough routing wrong");
  route_root_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2_q[0] && !pending_passthrough_mask_q[0]
      && !hardware_clear_enable_q[0]) |=> root_pending[LINE_LSB])
    else $error("root routing wrong");
  root_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    root_take == (|root_pending))
    else $error("root take mismatch");
  guest_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    guest_take == ((|guest_pending) && !(|root_pending)))
    else $error("guest take mismatch");
  // internal sources never reach root
  root_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    root_pending[LINE_LSB-1:0] == 2'b00)
    else $error("root low bits set");
  field_vs_a: assert property (@(posedge pclk) disable iff (!presetn)
    (guest_config_write && (guest_config_wdata[GC_VS_LSB +: 5]
      != interrupt_config_q[GC_VS_LSB +: 5])) |=> field_change_exc)
    else $error("spacing change missed");
  stat_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_q[EV_FIELD] && !(wr && paddr == OFF_IRQ_CLR && pwdata[EV_FIELD]))
      |=> stat_q[EV_FIELD])
    else $error("status bit dropped");
  prio_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (captured_guest_priority_level_q == PRIO_RST) |=> !guest_prio_irq)
    else $error("handoff with zero level");
  // irq level follows enabled status
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (|(stat_q & en_q)))
    else $error("irq level mismatch");
  // apb answer one cycle after setup
  ready_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("ready missing");
  // ready is a single-cycle pulse
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // read data captured at setup stands in access
  rdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd |-> (prdata == $past(rdata_d)))
    else $error("read data not stable");
endmodule
`default_nettype wire

/* irq_line_source.sv */
// Purpose: external interrupt source driving the shared lines
// Assumes: lines are active-high levels, no pull on them
// Notes:   lines follow a request one edge later
`timescale 1ns/1ps
`default_nettype none
module irq_line_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] want,
  output logic      [5:0] lines
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= 6'h00;
    end else begin
      lines <= want;
    end
  end
endmodule
`default_nettype wire

/* guest_interrupt_virtualization_tb_top.sv */
// Purpose: self-checking bench for guest interrupt virtualization
// Assumes: zero-wait APB slave, pending lags lines by 3 edges
// Notes:   random routing loop plus hand-written corners
`timescale 1ns/1ps
`default_nettype none
module guest_interrupt_virtualization_tb_top;
  import guest_irq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, root_pending, guest_pending;
  logic [31:0] pwdata, prdata, guest_config_wdata, q;
  logic [5:0]  want, external_irq_lines, pass, hc, vp, ln, old;
  logic [1:0]  guest_soft_irq;
  logic        guest_timer_irq, guest_mode, guest_config_write, irq;
  logic        root_take, guest_take, field_change_exc, guest_prio_irq, s;
  int          err_count, n_compared, seed, i, k;

  guest_irq_virt u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .external_irq_lines,
    .guest_timer_irq, .guest_soft_irq, .guest_mode, .guest_config_write,
    .guest_config_wdata, .root_pending, .guest_pending, .root_take,
    .guest_take, .field_change_exc, .guest_prio_irq, .irq);
  irq_line_source u_src (.pclk, .presetn, .want,
    .lines(external_irq_lines));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
    chk(s, 1'b0);
  endtask

  task automatic cfg(input logic [31:0] d, input logic e);
    logic seen;
    @(posedge pclk);
    guest_config_wdata <= d;
    guest_config_write <= 1'b1;
    @(posedge pclk);
    guest_config_write <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      seen |= field_change_exc;
    end
    chk(seen, e);
  endtask

  function automatic logic [7:0] eg(input logic [5:0] l, p, v);
    return {(l & p) | v, 2'b00};
  endfunction

  function automatic logic [7:0] er(input logic [5:0] l, p, v, h);
    return {l & ~(p | (v & h)), 2'b00};
  endfunction

  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    conclude;
  end

  initial begin
    seed = 32'h11d2;
    {psel, penable, pwrite, paddr, pwdata, want, old} = '0;
    {guest_soft_irq, guest_timer_irq, guest_mode} = '0;
    {guest_config_write, guest_config_wdata} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({root_pending, guest_pending, root_take, guest_take, irq}, 32'h0);
    rd(OFF_PASSTHRU, 32'h0);
    rd(OFF_VPEND, 32'h0);
    rd(OFF_HWCLR, 32'h0);
    rd(OFF_GCTRL, {26'h0, SEL_RST, SEL_RST});
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0);
    for (i = 0; i < 40; i++) begin
      pass = 6'($random(seed));
      hc = 6'($random(seed));
      vp = 6'($random(seed));
      ln = 6'($random(seed));
      wr(OFF_PASSTHRU, {26'h0, pass});
      wr(OFF_HWCLR, {26'h0, hc});
      wr(OFF_VPEND, {26'h0, vp});
      @(posedge pclk);
      want <= ln;
      guest_mode <= 1'($random(seed));
      // lines that fall clear injected bits with hardware clear
      vp = vp & ~(hc & old & ~ln);
      old = ln;
      repeat (6) @(posedge pclk);
      chk(guest_pending, eg(ln, pass, vp));
      chk(root_pending, er(ln, pass, vp, hc));
      chk(root_take, |er(ln, pass, vp, hc));
      chk(guest_take, |eg(ln, pass, vp) && !(|er(ln, pass, vp, hc)));
      rd(OFF_VPEND, {26'h0, vp});
      rd(OFF_HWCLR, {26'h0, hc});
    end
    wr(OFF_VPEND, 32'h0);
    wr(OFF_PASSTHRU, 32'h0);
    @(posedge pclk);
    want <= 6'h00;
    for (k = 0; k < 8; k++) begin
      wr(OFF_GCTRL, {26'h0, 3'(7 - k), 3'(k)});
      guest_timer_irq <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(guest_pending, 8'h01 << k);
      chk(root_pending, 8'h00);
      guest_timer_irq <= 1'b0;
      guest_soft_irq <= 2'b10;
      repeat (3) @(posedge pclk);
      chk(guest_pending, (8'h01 << (7 - k)) | 8'h02);
      guest_soft_irq <= 2'b00;
    end
    wr(OFF_IRQ_EN, 32'h3);
    cfg(32'h40, 1'b1);
    rd(OFF_IRQ_STAT, 32'h1);
    chk(irq, 1'b1);
    wr(OFF_IRQ_CLR, 32'h1);
    rd(OFF_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    cfg(32'hC0, 1'b1);
    cfg(32'h1C0, 1'b1);
    cfg(32'h1C0, 1'b0);
    cfg(32'h1C1, 1'b0);
    wr(OFF_IRQ_CLR, 32'h1);
    wr(OFF_PRIO, 32'h5);
    rd(OFF_PRIO, 32'h5);
    @(posedge pclk);
    guest_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    guest_mode <= 1'b1;
    k = 0;
    while (guest_prio_irq !== 1'b1 && k < 10) begin
      @(posedge pclk);
      k++;
    end
    chk(k < 10, 1'b1);
    rd(OFF_IRQ_STAT, 32'h2);
    wr(OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    wr(OFF_IRQ_EN, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({root_pending, guest_pending, irq, guest_prio_irq}, 32'h0);
    presetn <= 1'b1;
    rd(OFF_PRIO, 32'h0);
    rd(OFF_IRQ_EN, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
